// ### gpio_pkg.sv
// shared constants and types for the dual parallel port block
package gpio_pkg;
   localparam int          PA_WIDTH      = 8;
   localparam int          PB_WIDTH      = 4;
   localparam int          ADDR_WIDTH    = 3;
   localparam int          DATA_WIDTH    = 8;
   // register offsets
   localparam logic [2:0]  PA_LATCH_ADDR = 3'h0;
   localparam logic [2:0]  PB_LATCH_ADDR = 3'h1;
   localparam logic [2:0]  PA_DIR_ADDR   = 3'h4;
   localparam logic [2:0]  PB_DIR_ADDR   = 3'h5;
   // field positions
   localparam int          CLK_OUT_BIT   = 7;
   localparam int          KEY_LO        = 1;
   localparam int          KEY_HI        = 6;
   localparam int          TCH_PIN       = 2;
   localparam int          TIMER_EXTERNAL_CLOCK_PIN_PIN      = 3;
   localparam int          MCLK_PIN      = 0;
   // channel edge/level select value that leaves the pin to the port
   localparam logic [1:0]  ELS_PORT      = 2'h0;
   // prescale selection that picks the external timer clock pin
   localparam logic [2:0]  PS_EXT_CLK    = 3'h7;
   // reset values
   localparam logic [7:0]  PA_DIR_RST    = 8'h00;
   localparam logic [3:0]  PB_DIR_RST    = 4'h0;
   localparam logic [7:0]  DATA_ZERO     = 8'h00;

   typedef struct packed {
      logic [ADDR_WIDTH-1:0] addr;
      logic [DATA_WIDTH-1:0] wdata;
      logic                  wr;
      logic                  rd;
   } reg_req_t;

   typedef struct packed {
      logic [PB_WIDTH-1:0] o;
      logic [PB_WIDTH-1:0] oe;
   } pb_drive_t;
endpackage

// ### pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
module pin_sync #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_sync
);
   logic [W-1:0] meta_r;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r   <= '0;
         pin_sync <= '0;
      end else begin
         meta_r   <= pin_in;
         pin_sync <= meta_r;
      end
   end
endmodule

// ### dual_parallel_io_ports.sv
// two bidirectional parallel ports with keypad, timer and clock-out overrides
// Operation
// RULE1 - port a: eight pins, latch and direction
// RULE2 - port b: four pins, latch and direction
// RULE3 - port a direction one drives pin
// RULE4 - reset clears port a direction bits
// RULE5 - reset keeps port a latch contents
// RULE6 - port a read: latch if output, else pin
// RULE7 - port a latch writes always accepted
// RULE8 - latch write never alters input level
// RULE9 - keypad enable forces port a input
// RULE10 - pullups on only for keypad pins
// RULE11 - software loads latch before enabling output
// RULE12 - port b direction one drives pin
// RULE13 - reset clears port b direction bits
// RULE14 - reset keeps port b latch contents
// RULE15 - direction bit seven drives bus clock out
// RULE16 - pin two serves timer channel zero
// RULE17 - pin three feeds timer external clock
// RULE18 - software loads port b latch first
// RULE19 - port b read: latch if output, else pin
// RULE20 - direction reads return written bits, zeros
//
// The implementer's own choice: the strobed register port.
module dual_parallel_io_ports #(
   parameter int PA_W = gpio_pkg::PA_WIDTH,
   parameter int PB_W = gpio_pkg::PB_WIDTH
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   input  wire gpio_pkg::reg_req_t    reg_req,
   output logic [7:0]                 reg_rdata,
   input  wire logic [PA_W-1:0]       port_a_pin_in,
   output logic [PA_W-1:0]            port_a_pin_out,
   output logic [PA_W-1:0]            port_a_pin_oe,
   output logic [PA_W-1:0]            port_a_pullup_en,
   input  wire logic [PB_W-1:0]       port_b_pin_in,
   output logic [PB_W-1:0]            port_b_pin_out,
   output logic [PB_W-1:0]            port_b_pin_oe,
   input  wire logic [6:1]            keypad_pin_enable,
   input  wire logic [1:0]            channel_edge_level_select,
   input  wire logic                  timer_channel_out,
   output logic                       timer_channel_zero_pin,
   input  wire logic [2:0]            timer_prescale_select,
   output logic                       timer_external_clock_pin,
   input  wire logic                  bus_clock
);
   ////////////////////////////////////////////////////////////////////////
   // storage
   logic [PA_W-1:0] port_a_latch_r;
   logic [PA_W-1:0] port_a_dir_r;
   logic [PB_W-1:0] port_b_latch_r;
   logic [PB_W-1:0] port_b_dir_r;
   logic            bus_clock_out_enable_r;
   logic [PA_W-1:0] pa_sync;
   logic [PB_W-1:0] pb_sync;
   logic [PA_W-1:0] key_en;
   logic            tch_claim;
   logic            timer_external_clock_pin_claim;
   logic            wr_pa;
   logic            wr_pb;
   logic            wr_pa_dir;
   logic            wr_pb_dir;
   logic [7:0]      rdata_nxt;
   gpio_pkg::pb_drive_t pb_drv;

   always_comb begin
      key_en = '0;
      key_en[gpio_pkg::KEY_HI:gpio_pkg::KEY_LO] = keypad_pin_enable;
   end

   assign wr_pa     = reg_req.wr && reg_req.addr == gpio_pkg::PA_LATCH_ADDR;
   assign wr_pb     = reg_req.wr && reg_req.addr == gpio_pkg::PB_LATCH_ADDR;
   assign wr_pa_dir = reg_req.wr && reg_req.addr == gpio_pkg::PA_DIR_ADDR;
   assign wr_pb_dir = reg_req.wr && reg_req.addr == gpio_pkg::PB_DIR_ADDR;

   ////////////////////////////////////////////////////////////////////////
   // data latches have no reset: their contents survive a reset
   // RULE1 RULE7 port a latch
   // RULE5 no reset term
   always_ff @(posedge core_clk) begin
      if (wr_pa) begin
         port_a_latch_r <= reg_req.wdata[PA_W-1:0];
      end
   end

   // RULE2 port b latch
   // RULE14 RULE18 no reset, always written
   always_ff @(posedge core_clk) begin
      if (wr_pb) begin
         port_b_latch_r <= reg_req.wdata[PB_W-1:0];
      end
   end

   // RULE4 clears port a direction
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         port_a_dir_r <= gpio_pkg::PA_DIR_RST;
      end else if (wr_pa_dir) begin
         port_a_dir_r <= reg_req.wdata[PA_W-1:0];
      end
   end

   // RULE13 RULE15 clears port b direction and clock out
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         port_b_dir_r           <= gpio_pkg::PB_DIR_RST;
         bus_clock_out_enable_r <= 1'b0;
      end else if (wr_pb_dir) begin
         port_b_dir_r           <= reg_req.wdata[PB_W-1:0];
         bus_clock_out_enable_r <= reg_req.wdata[gpio_pkg::CLK_OUT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin inputs cross from the board
   pin_sync #(.W(PA_W)) u_sync_a (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .pin_in   (port_a_pin_in),
      .pin_sync (pa_sync)
   );

   pin_sync #(.W(PB_W)) u_sync_b (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .pin_in   (port_b_pin_in),
      .pin_sync (pb_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // pin drive
   // RULE3 RULE9 keypad use overrides the direction bit
   // RULE8 latch only reaches a pin that is driven
   assign port_a_pin_out = port_a_latch_r;
   assign port_a_pin_oe  = port_a_dir_r & ~key_en;
   // RULE10 pullups follow keypad enables
   assign port_a_pullup_en = key_en;

   // RULE16 timer claims pin two
   assign tch_claim  = channel_edge_level_select != gpio_pkg::ELS_PORT;
   // RULE17 timer clock claims pin three
   assign timer_external_clock_pin_claim = timer_prescale_select == gpio_pkg::PS_EXT_CLK;

   always_comb begin
      // RULE12 direction enables output buffer
      pb_drv.o  = port_b_latch_r;
      pb_drv.oe = port_b_dir_r;
      // RULE16 channel drives only when compare direction is set
      if (tch_claim) begin
         pb_drv.o[gpio_pkg::TCH_PIN]  = timer_channel_out;
      end
      // RULE17 clock pin is input while the timer takes it
      if (timer_external_clock_pin_claim) begin
         pb_drv.oe[gpio_pkg::TIMER_EXTERNAL_CLOCK_PIN_PIN] = 1'b0;
      end
      // RULE15 bus clock overrides pin zero
      if (bus_clock_out_enable_r) begin
         pb_drv.o[gpio_pkg::MCLK_PIN]  = bus_clock;
         pb_drv.oe[gpio_pkg::MCLK_PIN] = 1'b1;
      end
   end

   assign port_b_pin_out = pb_drv.o;
   assign port_b_pin_oe  = pb_drv.oe;
   assign timer_channel_zero_pin   = pb_sync[gpio_pkg::TCH_PIN];
   assign timer_external_clock_pin = pb_sync[gpio_pkg::TIMER_EXTERNAL_CLOCK_PIN_PIN];

   ////////////////////////////////////////////////////////////////////////
   // read path, data one cycle after the strobe
   always_comb begin
      rdata_nxt = gpio_pkg::DATA_ZERO;
      if (reg_req.addr == gpio_pkg::PA_LATCH_ADDR) begin
         // RULE6 latch for outputs, pin for inputs
         rdata_nxt[PA_W-1:0] = (port_a_dir_r & port_a_latch_r) | (~port_a_dir_r & pa_sync);
      end else if (reg_req.addr == gpio_pkg::PB_LATCH_ADDR) begin
         // RULE19 latch for outputs, pin for inputs
         rdata_nxt[PB_W-1:0] = (port_b_dir_r & port_b_latch_r) | (~port_b_dir_r & pb_sync);
      end else if (reg_req.addr == gpio_pkg::PA_DIR_ADDR) begin
         // RULE20 direction readback
         rdata_nxt[PA_W-1:0] = port_a_dir_r;
      end else if (reg_req.addr == gpio_pkg::PB_DIR_ADDR) begin
         // RULE20 unused bits read zero
         rdata_nxt[PB_W-1:0] = port_b_dir_r;
         rdata_nxt[gpio_pkg::CLK_OUT_BIT] = bus_clock_out_enable_r;
      end
   end

   // read data holds only in the cycle after a read, zero otherwise
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= gpio_pkg::DATA_ZERO;
      end else if (reg_req.rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= gpio_pkg::DATA_ZERO;
      end
   end
endmodule

// ### gpio_ports_assertions.sv
// concurrent checks on the parallel port block's pins and register bus
module gpio_ports_assertions (
   input wire logic               core_clk,
   input wire logic               rst_b,
   input wire gpio_pkg::reg_req_t reg_req,
   input wire logic [7:0]         port_a_pin_out,
   input wire logic [7:0]         port_a_pin_oe,
   input wire logic [7:0]         port_a_pullup_en,
   input wire logic [3:0]         port_b_pin_out,
   input wire logic [3:0]         port_b_pin_oe,
   input wire logic [6:1]         keypad_pin_enable,
   input wire logic [1:0]         channel_edge_level_select,
   input wire logic               timer_channel_out,
   input wire logic [2:0]         timer_prescale_select,
   input wire logic               bus_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   wire logic [7:0] kmask = {1'b0, keypad_pin_enable, 1'b0};
   wire logic       wr_a = reg_req.wr && reg_req.addr == gpio_pkg::PA_LATCH_ADDR;
   wire logic       wr_ad = reg_req.wr && reg_req.addr == gpio_pkg::PA_DIR_ADDR;
   wire logic       wr_bd = reg_req.wr && reg_req.addr == gpio_pkg::PB_DIR_ADDR;
   ////////////////////////////////////////////////////////////
   chk_keypad_input: assert property ((port_a_pin_oe & kmask) == 8'h00)
      else $error("keypad pin driven");
   chk_pullup_keypad: assert property (port_a_pullup_en == kmask)
      else $error("pullup mismatch");
   chk_reset_inputs: assert property ($rose(rst_b) |-> !port_a_pin_oe && !port_b_pin_oe)
      else $error("pins driven after reset");
   chk_dir_a_write: assert property (wr_ad |=> port_a_pin_oe == ($past(reg_req.wdata) & ~kmask))
      else $error("port a enable wrong");
   chk_latch_a_write: assert property (wr_a |=> port_a_pin_out == $past(reg_req.wdata))
      else $error("port a latch not written");
   chk_dir_b_write: assert property (wr_bd |=> port_b_pin_oe[2:1] == $past(reg_req.wdata[2:1]))
      else $error("port b enable wrong");
   chk_clk_out_on: assert property (wr_bd && reg_req.wdata[7] |=> port_b_pin_oe[0] && port_b_pin_out[0] == bus_clock)
      else $error("clock out missing");
   chk_timer_external_clock_pin_release: assert property (timer_prescale_select == gpio_pkg::PS_EXT_CLK |-> !port_b_pin_oe[3])
      else $error("timer clock pin driven");
   chk_tch_drive: assert property (channel_edge_level_select != gpio_pkg::ELS_PORT |-> port_b_pin_out[2] == timer_channel_out)
      else $error("timer channel not on pin");
   cover property ($rose(rst_b));
   cover property (wr_bd && reg_req.wdata[7]);
   cover property (keypad_pin_enable != 6'h00 && port_a_pin_oe != 8'h00);
endmodule

// ### board_model.sv
// board side of the pads: each pad is driven, pulled up, or set by the board
module board_model (
   input  wire logic [7:0] a_out,
   input  wire logic [7:0] a_oe,
   input  wire logic [7:0] a_pu,
   input  wire logic [7:0] a_ext,
   output logic      [7:0] a_pad,
   input  wire logic [3:0] b_out,
   input  wire logic [3:0] b_oe,
   input  wire logic [3:0] b_ext,
   output logic      [3:0] b_pad
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////
   // the board always drives released pads, so no pad floats
   assign a_pad = (a_oe & a_out) | (~a_oe & (a_pu | a_ext));
   assign b_pad = (b_oe & b_out) | (~b_oe & b_ext);
endmodule

// ### testbench.sv
// self-checking bench for the dual parallel port block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic               core_clk, rst_b, tco, tch, tck, bclk;
   gpio_pkg::reg_req_t req;
   logic [7:0]         rdata, a_out, a_oe, a_pu, a_ext, a_pad;
   logic [3:0]         b_out, b_oe, b_ext, b_pad;
   logic [6:1]         kp;
   logic [1:0]         els;
   logic [2:0]         ps;
   int                 n_errors, samples_checked, cyc;
   dual_parallel_io_ports dut (.core_clk(core_clk), .rst_b(rst_b), .reg_req(req),
      .reg_rdata(rdata), .port_a_pin_in(a_pad), .port_a_pin_out(a_out),
      .port_a_pin_oe(a_oe), .port_a_pullup_en(a_pu), .port_b_pin_in(b_pad),
      .port_b_pin_out(b_out), .port_b_pin_oe(b_oe), .keypad_pin_enable(kp),
      .channel_edge_level_select(els), .timer_channel_out(tco),
      .timer_channel_zero_pin(tch), .timer_prescale_select(ps),
      .timer_external_clock_pin(tck), .bus_clock(bclk));
   board_model board (.a_out(a_out), .a_oe(a_oe), .a_pu(a_pu), .a_ext(a_ext),
      .a_pad(a_pad), .b_out(b_out), .b_oe(b_oe), .b_ext(b_ext), .b_pad(b_pad));
   ////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      bclk <= ~bclk;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge core_clk);
      req.wr <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge core_clk);
      req.rd <= 1'b0;
      @(negedge core_clk);
      chk(rdata, exp);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic test_reset();
      rdc(gpio_pkg::PA_DIR_ADDR, 8'h00);
      rdc(gpio_pkg::PB_DIR_ADDR, 8'h00);
      rdc(3'h2, 8'h00);
      rdc(gpio_pkg::PA_LATCH_ADDR, 8'h3c);
      $display("reset test done");
   endtask
   task automatic test_port_a();
      wr(gpio_pkg::PA_LATCH_ADDR, 8'ha5);
      chk(a_oe, 8'h00);
      rdc(gpio_pkg::PA_LATCH_ADDR, 8'h3c);
      wr(gpio_pkg::PA_DIR_ADDR, 8'h0f);
      rdc(gpio_pkg::PA_LATCH_ADDR, 8'h35);
      chk(a_out, 8'ha5);
      chk(a_oe, 8'h0f);
      rdc(gpio_pkg::PA_DIR_ADDR, 8'h0f);
      @(posedge core_clk);
      kp <= 6'h3f;
      wr(gpio_pkg::PA_DIR_ADDR, 8'hff);
      chk(a_oe, 8'h81);
      chk(a_pu, 8'h7e);
      // keypad use leaves the read mux on the direction bits
      rdc(gpio_pkg::PA_LATCH_ADDR, 8'ha5);
      @(posedge core_clk);
      kp <= 6'h00;
      @(negedge core_clk);
      chk(a_pu, 8'h00);
      $display("port a test done");
   endtask
   task automatic test_port_b();
      wr(gpio_pkg::PB_LATCH_ADDR, 8'h0a);
      wr(gpio_pkg::PB_DIR_ADDR, 8'h06);
      rdc(gpio_pkg::PB_LATCH_ADDR, 8'h03);
      chk({4'h0, b_oe}, 8'h06);
      // pin zero direction left clear so only the clock enable can drive it
      wr(gpio_pkg::PB_DIR_ADDR, 8'h86);
      rdc(gpio_pkg::PB_DIR_ADDR, 8'h86);
      chk({4'h0, b_oe}, 8'h07);
      chk({7'h0, b_out[0]}, {7'h0, bclk});
      @(negedge core_clk);
      chk({7'h0, b_out[0]}, {7'h0, bclk});
      $display("port b test done");
   endtask
   task automatic test_timer();
      @(posedge core_clk);
      els <= 2'h1;
      tco <= 1'b1;
      ps <= gpio_pkg::PS_EXT_CLK;
      b_ext <= 4'hd;
      wr(gpio_pkg::PB_DIR_ADDR, 8'h0f);
      chk({4'h0, b_oe}, 8'h07);
      chk({4'h0, b_out}, 8'h0e);
      repeat (3) @(negedge core_clk);
      chk({6'h0, tck, tch}, 8'h03);
      @(posedge core_clk);
      els <= 2'h0;
      ps <= 3'h0;
      @(negedge core_clk);
      chk({b_oe, b_out}, 8'hfa);
      $display("timer test done");
   endtask
   task automatic test_second_reset();
      // clock out on before reset so its clearing is visible
      wr(gpio_pkg::PB_DIR_ADDR, 8'h80);
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      @(negedge core_clk);
      chk(a_out, 8'ha5);
      chk({b_oe, b_out}, 8'h0a);
      chk(a_oe, 8'h00);
      rdc(gpio_pkg::PB_DIR_ADDR, 8'h00);
      $display("second reset test done");
   endtask
   initial begin
      {rst_b, req, kp, els, tco, ps, bclk, cyc, n_errors, samples_checked} = '0;
      a_ext = 8'h3c;
      b_ext = 4'h5;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      test_reset();
      test_port_a();
      test_port_b();
      test_timer();
      test_second_reset();
      finish_test();
   end
endmodule
bind dual_parallel_io_ports gpio_ports_assertions chk_i (.core_clk(core_clk), .rst_b(rst_b),
   .reg_req(reg_req), .port_a_pin_out(port_a_pin_out), .port_a_pin_oe(port_a_pin_oe),
   .port_a_pullup_en(port_a_pullup_en), .port_b_pin_out(port_b_pin_out),
   .port_b_pin_oe(port_b_pin_oe), .keypad_pin_enable(keypad_pin_enable),
   .channel_edge_level_select(channel_edge_level_select),
   .timer_channel_out(timer_channel_out), .timer_prescale_select(timer_prescale_select),
   .bus_clock(bus_clock));
